/* File: ram_pointer_consts.vh */
`ifndef RAM_POINTER_CONSTS_VH
`define RAM_POINTER_CONSTS_VH

// pointer unit register width, larger variant (smaller variant uses 9)
`define RPU_WIDTH_LARGE     16
`define RPU_WIDTH_SMALL     9
// number of pointer registers
`define RPU_NUM_PTRS        4
// reset value of the wrap end register (zero means wrap off)
`define RPU_WRAP_END_RESET  16'h0000
// reset value of start register and pointers
`define RPU_REG_RESET       16'h0000
// post-modify selector codes
`define RPU_MOD_NONE        2'h0
`define RPU_MOD_INC1        2'h1
`define RPU_MOD_DEC1        2'h2
`define RPU_MOD_STEP        2'h3

`endif

/* File: wrap_compare.v */
`timescale 1ns/1ps
`include "ram_pointer_consts.vh"

module wrap_compare #(
  parameter WIDTH = `RPU_WIDTH_LARGE
) (
  // pointer before the update
  input  wire [WIDTH-1:0] ptr_value,
  input  wire [1:0]       modify_sel,
  input  wire [WIDTH-1:0] step_value,
  // wrap bounds
  input  wire [WIDTH-1:0] wrap_first_location,
  input  wire [WIDTH-1:0] wrap_last_location,
  // result
  output reg  [WIDTH-1:0] next_ptr,
  output wire             wrap_taken
);

  wire wrap_on;
  reg  [WIDTH-1:0] plain_next;

  // any nonzero end value turns wrapping on
  assign wrap_on = |wrap_last_location;

  // full-width match on the pre-increment value, only for +1 accesses
  assign wrap_taken = wrap_on && (modify_sel == `RPU_MOD_INC1) &&
                      (ptr_value == wrap_last_location);

  // ordinary post-modify, identical to non-wrap behaviour
  always @* begin
    case (modify_sel)
      `RPU_MOD_INC1: plain_next = ptr_value + {{(WIDTH-1){1'b0}}, 1'b1};
      `RPU_MOD_DEC1: plain_next = ptr_value - {{(WIDTH-1){1'b0}}, 1'b1};
      `RPU_MOD_STEP: plain_next = ptr_value + step_value;
      default:       plain_next = ptr_value;
    endcase
  end

  // reload from the start register on a match
  always @* begin
    if (wrap_taken) begin
      next_ptr = wrap_first_location;
    end else begin
      next_ptr = plain_next;
    end
  end

endmodule

/* File: ram_pointer_unit.v */
// Behaviour
// - a start register holds the first RAM location of the circular buffer.
// - an end register holds the last RAM location, the wrap point.
// - each +1 access (RPU_MOD_INC1) compares the pre-increment pointer with the end register.
// - on equality the pointer reloads from the start register.
// - wrapping is on whenever the end register is nonzero.
// - reset clears the end register, so wrapping starts off.
// - start, end, pointer and address registers are 9 bits (small) or 16 bits (large) wide; wrap_event is 1 bit.
// - with wrapping off the start register is free general storage.
`timescale 1ns/1ps
`include "ram_pointer_consts.vh"

module ram_pointer_unit #(
  parameter WIDTH    = `RPU_WIDTH_LARGE,
  parameter NUM_PTRS = `RPU_NUM_PTRS,
  parameter SEL_W    = 2
) (
  // clock and reset
  input  wire             ref_clk,
  input  wire             resetn,
  // register writes from the datapath
  input  wire             wr_en,
  input  wire [2:0]       wr_sel,
  input  wire [WIDTH-1:0] wr_data,
  // memory access through a pointer
  input  wire             access_en,
  input  wire [SEL_W-1:0] access_ptr,
  input  wire [1:0]       modify_sel,
  input  wire [WIDTH-1:0] step_value,
  // address to RAM and register views
  output reg  [WIDTH-1:0] ram_addr,
  output reg              wrap_event,
  output wire [WIDTH-1:0] wrap_first_location,
  output wire [WIDTH-1:0] wrap_last_location,
  output wire [WIDTH*NUM_PTRS-1:0] ptr_values
);

  // write selector codes: pointers 0..3, then start and end
  localparam [2:0] SEL_FIRST = 3'h4;
  localparam [2:0] SEL_LAST  = 3'h5;

  reg  [WIDTH-1:0] first_loc;
  reg  [WIDTH-1:0] last_loc;
  reg  [WIDTH-1:0] ptr_reg [0:NUM_PTRS-1];
  wire [WIDTH-1:0] cur_ptr;
  wire [WIDTH-1:0] next_ptr;
  wire             wrap_taken;

  assign cur_ptr             = ptr_reg[access_ptr];
  assign wrap_first_location = first_loc;
  assign wrap_last_location  = last_loc;

  wrap_compare #(
    .WIDTH(WIDTH)
  ) u_cmp (
    .ptr_value           (cur_ptr),
    .modify_sel          (modify_sel),
    .step_value          (step_value),
    .wrap_first_location (first_loc),
    .wrap_last_location  (last_loc),
    .next_ptr            (next_ptr),
    .wrap_taken          (wrap_taken)
  );

  // start and end registers; start is plain storage when end is zero
  always @(posedge ref_clk) begin
    if (!resetn) begin
      last_loc  <= `RPU_WRAP_END_RESET;
      first_loc <= `RPU_REG_RESET;
    end else if (wr_en) begin
      if (wr_sel == SEL_FIRST) begin
        first_loc <= wr_data;
      end
      if (wr_sel == SEL_LAST) begin
        last_loc <= wr_data;
      end
    end
  end

  // pointer registers; an access update wins over a same-cycle write
  genvar i;
  generate
    for (i = 0; i < NUM_PTRS; i = i + 1) begin : g_ptr
      always @(posedge ref_clk) begin
        if (!resetn) begin
          ptr_reg[i] <= `RPU_REG_RESET;
        end else if (access_en && (access_ptr == i)) begin
          ptr_reg[i] <= next_ptr;
        end else if (wr_en && (wr_sel == i)) begin
          ptr_reg[i] <= wr_data;
        end
      end
      assign ptr_values[WIDTH*i +: WIDTH] = ptr_reg[i];
    end
  endgenerate

  // registered address and wrap marker; address is the pre-modify value
  always @(posedge ref_clk) begin
    if (!resetn) begin
      ram_addr   <= `RPU_REG_RESET;
      wrap_event <= 1'b0;
    end else begin
      wrap_event <= access_en & wrap_taken;
      if (access_en) begin
        ram_addr <= cur_ptr;
      end
    end
  end

endmodule

/* File: ram_pointer_chk.sv */
`timescale 1ns/1ps
module ram_pointer_chk #(parameter WIDTH = 16, NUM_PTRS = 4, SEL_W = 2) (
  // requests
  input wire ref_clk, resetn, wr_en, access_en, wrap_event,
  input wire [2:0] wr_sel,
  input wire [1:0] modify_sel,
  input wire [SEL_W-1:0] access_ptr,
  // data and views
  input wire [WIDTH-1:0] wr_data, step_value, ram_addr,
  input wire [WIDTH-1:0] wrap_first_location, wrap_last_location,
  input wire [WIDTH*NUM_PTRS-1:0] ptr_values
);
  // pointer chosen now and in the previous cycle, whether or not that cycle was an access
  logic [SEL_W-1:0] last_sel;
  wire [WIDTH-1:0] cur = ptr_values[access_ptr*WIDTH +: WIDTH];
  wire [WIDTH-1:0] upd = ptr_values[last_sel*WIDTH +: WIDTH];
  wire hit = wrap_last_location != 0 && cur == wrap_last_location;
  always @(posedge ref_clk) last_sel <= access_ptr;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  start_load_a: assert property (wr_en && wr_sel == 4 |=>
    wrap_first_location == $past(wr_data)) else $error("start load");
  end_load_a: assert property (wr_en && wr_sel == 5 |=>
    wrap_last_location == $past(wr_data)) else $error("end load");
  addr_pre_a: assert property (access_en |=> ram_addr == $past(cur))
    else $error("address");
  wrap_load_a: assert property (access_en && modify_sel == 1 && hit |=>
    wrap_event && upd == $past(wrap_first_location)) else $error("wrap");
  plain_inc_a: assert property (access_en && modify_sel == 1 && !hit |=>
    !wrap_event && upd == $past(cur) + 1'b1) else $error("increment");
  end_reset_a: assert property (disable iff (1'b0) !resetn |=>
    wrap_last_location == 0) else $error("end reset");
  step_mod_a: assert property (access_en && modify_sel == 3 |=>
    !wrap_event && upd == $past(cur) + $past(step_value)) else $error("step");
  start_hold_a: assert property (!(wr_en && wr_sel == 4) |=>
    $stable(wrap_first_location)) else $error("start hold");
  // main scenarios reached
  cover property (access_en && modify_sel == 1 && hit);
  cover property (access_en && modify_sel == 1 && !hit);
  cover property (access_en && modify_sel == 3);
endmodule
bind ram_pointer_unit ram_pointer_chk #(.WIDTH(WIDTH), .NUM_PTRS(NUM_PTRS), .SEL_W(SEL_W)) chk (.*);

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 0, resetn = 0, wr_en = 0, access_en = 0, wrap_event;
  logic [2:0] wr_sel = 0;
  logic [1:0] access_ptr = 0, modify_sel = 0;
  logic [15:0] wr_data = 0, step_value = 0, ram_addr, first, last;
  logic [15:0] want [4] = '{16'h0012, 16'h0010, 16'h0011, 16'h0017};
  logic [63:0] ptr_values;
  int errors = 0, comparisons = 0;
  ram_pointer_unit dut (.ref_clk, .resetn, .wr_en, .wr_sel, .wr_data, .access_en, .access_ptr,
    .modify_sel, .step_value, .ram_addr, .wrap_event, .wrap_first_location(first),
    .wrap_last_location(last), .ptr_values);
  initial forever #5 ref_clk = ~ref_clk;
  // one write or access, then let its update land
  task automatic op(bit a, logic [2:0] s, logic [15:0] d, logic [1:0] m = 1);
    @(posedge ref_clk);
    {wr_en, access_en, wr_sel, access_ptr, wr_data, step_value, modify_sel} <= {!a, a, s, s[1:0], d, d, m};
    @(posedge ref_clk);
    {wr_en, access_en} <= 2'h0;
    #1;
  endtask
  task automatic chk(logic [15:0] g, e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task print_verdict;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // walk up to the last location and wrap
  task t_wrap;
    op(0, 4, 16'h0010); op(0, 5, 16'h0012); op(0, 0, 16'h0010);
    chk(first, 16'h0010);
    chk(last, 16'h0012);
    for (int i = 0; i < 3; i++) begin
      op(1, 0, 0);
      chk(ram_addr, 16'h0010 + i);
    end
    chk(ptr_values[15:0], 16'h0010);
    chk(wrap_event, 1);
    $display("wrap done");
  endtask
  // every modify code from the last location
  task t_modes;
    for (int m = 0; m < 4; m++) begin
      op(0, 2, 16'h0012);
      op(1, 2, 16'h0005, m);
      chk(ptr_values[47:32], want[m]);
    end
    $display("modes done");
  endtask
  // end cleared: pointer zero must not wrap
  task t_off;
    op(0, 5, 0); op(0, 4, 16'h0013); op(0, 1, 0);
    op(1, 1, 0);
    chk(ptr_values[31:16], 16'h0001);
    $display("off done");
  endtask
  // reset in mid-run clears the end
  task t_reset;
    op(0, 5, 16'h0012);
    @(posedge ref_clk);
    resetn <= 0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1;
    #1 chk(last, 0);
    chk(ram_addr, 0);
    chk(ptr_values[15:0], 0);
    op(1, 0, 0);
    chk(ptr_values[15:0], 16'h0001);
    $display("reset done");
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    resetn <= 1;
    chk(last, 0);
    t_wrap;
    t_modes;
    t_off;
    t_reset;
    print_verdict;
  end
  // watchdog: the sequence needs about 530 ns
  initial begin
    #20000 errors++;
    print_verdict;
  end
endmodule
